// ==== core/sfb_top.sv ====
// Safety function blocks: input monitors, combining logic and AXI4-Lite registers
`default_nettype none
module sfb_top #(
    parameter int unsigned TICK_CYCLES = sfb_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire sfb_pkg::sfb_axi_req_t axi_req,
    output var sfb_pkg::sfb_axi_rsp_t axi_rsp,
    input wire sfb_pkg::sfb_field_t field_pins,
    output var sfb_pkg::sfb_safe_t safe_out,
    output var logic [3:0] table_result,
    output var logic [3:0] selector_value,
    output var logic [3:0] monitor_error,
    output var logic error_state
);
    import sfb_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [3:0] sfb_ones(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction : sfb_ones

    function automatic logic [3:0] sfb_first(input logic [7:0] v);
        logic [3:0] p;
        p = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                p = 4'(i + 1);
            end
        end
        return p;
    endfunction : sfb_first

    function automatic logic [TW-1:0] sfb_inc(input logic [TW-1:0] c);
        return (&c) ? c : c + 16'h0001;
    endfunction : sfb_inc

    function automatic sfb_reg_t sfb_decode(input logic [31:0] a);
        sfb_reg_t r;
        r = R_NONE;
        if (a[31:8] == 24'h000000 && a[1:0] == 2'h0) begin
            if (a[7:5] == TBL_PAGE) begin
                r = R_TBL;
            end else begin
                unique case (a[7:0])
                    CTRL_OFF: r = R_CTRL;
                    MASK_OFF: r = R_MASK;
                    SIM_OFF: r = R_SIM;
                    DLY_OFF: r = R_DLY;
                    PLS_OFF: r = R_PLS;
                    STAT_OFF: r = R_STAT;
                    default: r = R_NONE;
                endcase
            end
        end
        return r;
    endfunction : sfb_decode

    ////////////////////////////////////////////////////////////////////////
    // State declarations
    logic aw_held_reg, w_held_reg, awready_reg, wready_reg, bvalid_reg;
    logic arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] awaddr_reg, wdata_reg, rdata_reg;
    logic [3:0] wstrb_reg;
    logic [31:0] ctrl_reg, mask_reg;
    logic [TW-1:0] sim_limit_reg, delay_length_reg, pulse_length_reg;
    logic [3:0] conversion_table [TBL_N];
    sfb_field_t pin_s1_reg, pin_s2_reg, eval_reg;
    sfb_mode_t mode_reg;
    logic [31:0] tick_cnt_reg;
    logic tick_reg;
    logic single_res_reg, static_res_reg, dep_res_reg, ind_res_reg, sel_ok_reg;
    logic single_err_reg, dep_err_reg, ind_err_reg, sel_err_reg, sim_err_reg;
    logic [TW-1:0] sim_cnt_reg, dly_cnt_reg, pls_cnt_reg;
    logic dly_in_q_reg, pls_in_q_reg, ctl_q_reg;
    logic [3:0] sel_value_reg, table_reg;
    sfb_safe_t safe_reg;
    logic do_write, sync_clr, tick;
    sfb_reg_t wsel, rsel;
    logic [31:0] rd_data, wr_val;
    logic [7:0] pos_mask, sel_act;
    logic [3:0] pos_cnt, tbl_cnt, sel_n;
    logic dep_a, dep_b, ind_a, ind_b;
    logic [4:0] lv, m_and, m_or, m_nor;
    logic and_v, or_v, nor_v, dly_exp, ctl_edge;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel
    assign wsel = sfb_decode(awaddr_reg);
    assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wr_val[8*i +: 8] = wstrb_reg[i] ? wdata_reg[8*i +: 8] : 8'h00;
        end
    end

    // Address and data latch in either order, response after both
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            awaddr_reg <= 32'h0000_0000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else begin
            if (axi_req.awvalid && awready_reg) begin
                aw_held_reg <= 1'b1;
                awready_reg <= 1'b0;
                awaddr_reg <= axi_req.awaddr;
            end
            if (axi_req.wvalid && wready_reg) begin
                w_held_reg <= 1'b1;
                wready_reg <= 1'b0;
                wdata_reg <= axi_req.wdata;
                wstrb_reg <= axi_req.wstrb;
            end
            if (do_write) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= (wsel == R_NONE) ? RESP_SLVERR : RESP_OKAY;
            end
            if (bvalid_reg && axi_req.bready) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // Configuration registers; unstrobed CTRL and MASK bytes keep their value, timer and table registers take zero there
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= CTRL_RST;
            mask_reg <= MASK_RST;
            sim_limit_reg <= TIME_RST;
            delay_length_reg <= TIME_RST;
            pulse_length_reg <= TIME_RST;
            for (int i = 0; i < TBL_N; i++) begin
                conversion_table[i] <= 4'h0;
            end
        end else if (do_write) begin
            for (int i = 0; i < 4; i++) begin
                if (wstrb_reg[i]) begin
                    unique case (wsel)
                        R_CTRL: ctrl_reg[8*i +: 8] <= wr_val[8*i +: 8];
                        R_MASK: mask_reg[8*i +: 8] <= wr_val[8*i +: 8];
                        default: ;
                    endcase
                end
            end
            unique case (wsel)
                R_SIM: sim_limit_reg <= wr_val[TW-1:0];
                R_DLY: delay_length_reg <= wr_val[TW-1:0];
                R_PLS: pulse_length_reg <= wr_val[TW-1:0];
                R_TBL: conversion_table[awaddr_reg[TBL_IDX_LSB +: 3]] <= wr_val[3:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel
    assign rsel = sfb_decode(axi_req.araddr);
    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (rsel)
            R_CTRL: rd_data = ctrl_reg;
            R_MASK: rd_data = mask_reg;
            R_SIM: rd_data[TW-1:0] = sim_limit_reg;
            R_DLY: rd_data[TW-1:0] = delay_length_reg;
            R_PLS: rd_data[TW-1:0] = pulse_length_reg;
            R_TBL: rd_data[3:0] = conversion_table[axi_req.araddr[TBL_IDX_LSB +: 3]];
            R_STAT: begin
                rd_data[S_SAFE_LSB +: 6] = safe_reg;
                rd_data[S_MON_LSB +: 5] = lv;
                rd_data[S_ERR_LSB +: 4] = {sel_err_reg, ind_err_reg, dep_err_reg,
                    single_err_reg};
                rd_data[S_SEL_LSB +: 4] = sel_value_reg;
                rd_data[S_STATE] = (mode_reg == SFB_ERROR);
            end
            R_NONE: rd_data = 32'h0000_0000;
        endcase
    end

    // One read at a time; data captured at the address handshake
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else if (axi_req.arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_data;
            rresp_reg <= (rsel == R_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (rvalid_reg && axi_req.rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Field pins: two-flop synchroniser, then evaluation register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end else begin
            pin_s1_reg <= field_pins;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // Inputs freeze once the module is in error state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            eval_reg <= '0;
        end else if (mode_reg == SFB_RUN) begin
            eval_reg <= pin_s2_reg;
        end
    end

    // Error state is left only through reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_reg <= SFB_RUN;
        end else begin
            unique case (mode_reg)
                SFB_RUN: begin
                    if (ctrl_reg[C_FORCE_ERR] || (ctrl_reg[C_ERR_LOCK] &&
                        (single_err_reg | dep_err_reg | ind_err_reg | sel_err_reg))) begin
                        mode_reg <= SFB_ERROR;
                    end
                end
                SFB_ERROR: mode_reg <= SFB_ERROR;
            endcase
        end
    end
    assign sync_clr = (mode_reg == SFB_ERROR);

    ////////////////////////////////////////////////////////////////////////
    // Common timebase for every timer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg >= 32'(TICK_CYCLES - 1)) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
            tick_reg <= 1'b0;
        end
    end
    assign tick = tick_reg;

    ////////////////////////////////////////////////////////////////////////
    // Single contact and static signal monitors
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            single_res_reg <= 1'b0;
            single_err_reg <= 1'b0;
            static_res_reg <= 1'b0;
        end else begin
            single_res_reg <= eval_reg.single & ~eval_reg.single_flt;
            single_err_reg <= eval_reg.single_flt;
            static_res_reg <= eval_reg.stat;
        end
    end

    // Pair inputs normalised so that 1 means normal state
    assign dep_a = eval_reg.dep[0];
    assign dep_b = eval_reg.dep[1] ^ ctrl_reg[C_DEP_CFG];
    assign ind_a = eval_reg.ind[0];
    assign ind_b = eval_reg.ind[1] ^ ctrl_reg[C_IND_CFG];

    // Simultaneity: mismatch may last the limit, error latches until both leave
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sim_cnt_reg <= TIME_RST;
            sim_err_reg <= 1'b0;
        end else if (sync_clr || !(dep_a ^ dep_b)) begin
            sim_cnt_reg <= TIME_RST;
            if (!dep_a && !dep_b && !sync_clr) begin
                sim_err_reg <= 1'b0;
            end
        end else begin
            if (tick) begin
                sim_cnt_reg <= sfb_inc(sim_cnt_reg);
            end
            if (sim_cnt_reg > sim_limit_reg) begin
                sim_err_reg <= 1'b1;
            end
        end
    end

    // Pair monitors
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dep_res_reg <= 1'b0;
            dep_err_reg <= 1'b0;
            ind_res_reg <= 1'b0;
            ind_err_reg <= 1'b0;
        end else begin
            dep_err_reg <= sim_err_reg | (|eval_reg.dep_flt);
            dep_res_reg <= dep_a & dep_b & ~sim_err_reg & ~(|eval_reg.dep_flt);
            ind_err_reg <= |eval_reg.ind_flt;
            ind_res_reg <= ind_a & ind_b & ~(|eval_reg.ind_flt);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode selector; out-of-range counts clamp to 2 or 8
    always_comb begin
        pos_cnt = ctrl_reg[C_POS_LSB +: 4];
        if (pos_cnt < POS_MIN) begin
            pos_cnt = POS_MIN;
        end else if (pos_cnt > POS_MAX) begin
            pos_cnt = POS_MAX;
        end
        pos_mask = 8'hFF >> (4'h8 - pos_cnt);
        sel_act = eval_reg.sel & pos_mask;
        sel_n = sfb_ones(sel_act);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sel_err_reg <= 1'b0;
            sel_ok_reg <= 1'b0;
            sel_value_reg <= 4'h0;
        end else if (sel_n != 4'h1 || |(eval_reg.sel_flt & pos_mask)) begin
            sel_err_reg <= 1'b1;
            sel_ok_reg <= 1'b0;
            sel_value_reg <= 4'h0;
        end else begin
            sel_err_reg <= 1'b0;
            sel_ok_reg <= 1'b1;
            sel_value_reg <= sfb_first(sel_act);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Combining logic over the masked monitor results
    assign lv = {sel_ok_reg, ind_res_reg, dep_res_reg, static_res_reg, single_res_reg};
    assign m_and = mask_reg[M_AND_LSB +: 5];
    assign m_or = mask_reg[M_OR_LSB +: 5];
    assign m_nor = mask_reg[M_NOR_LSB +: 5];
    assign and_v = (|m_and) & (&(lv | ~m_and));
    assign or_v = |(lv & m_or);
    assign nor_v = (|m_nor) & ~(|(lv & m_nor));

    // Delay timer counts stable time of the AND result
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dly_in_q_reg <= 1'b0;
            dly_cnt_reg <= TIME_RST;
        end else begin
            dly_in_q_reg <= and_v;
            if (sync_clr || and_v != dly_in_q_reg) begin
                dly_cnt_reg <= TIME_RST;
            end else if (tick) begin
                dly_cnt_reg <= sfb_inc(dly_cnt_reg);
            end
        end
    end
    assign dly_exp = (dly_cnt_reg >= delay_length_reg) && (and_v == dly_in_q_reg);

    // Pulse timer, started by a falling edge of the single contact result
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pls_in_q_reg <= 1'b0;
            pls_cnt_reg <= TIME_RST;
        end else begin
            pls_in_q_reg <= single_res_reg;
            if (sync_clr || (pls_in_q_reg && !single_res_reg)) begin
                pls_cnt_reg <= TIME_RST;
            end else if (tick && safe_reg.pulse_o) begin
                pls_cnt_reg <= sfb_inc(pls_cnt_reg);
            end
        end
    end

    // Start control edge from the static signal result
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctl_q_reg <= 1'b0;
        end else begin
            ctl_q_reg <= static_res_reg;
        end
    end
    assign ctl_edge = ctrl_reg[C_START_FALL] ? (ctl_q_reg & ~static_res_reg)
                                             : (~ctl_q_reg & static_res_reg);

    ////////////////////////////////////////////////////////////////////////
    // Safety outputs, all forced open in error state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            safe_reg <= '0;
        end else if (sync_clr) begin
            safe_reg <= '0;
        end else begin
            safe_reg.and_o <= and_v;
            safe_reg.or_o <= or_v;
            safe_reg.nor_o <= nor_v;
            if (!ctrl_reg[C_DLY_OFF]) begin
                safe_reg.delay_o <= and_v & (dly_exp | safe_reg.delay_o);
            end else begin
                safe_reg.delay_o <= and_v | (~dly_exp & safe_reg.delay_o);
            end
            if (pls_in_q_reg && !single_res_reg) begin
                safe_reg.pulse_o <= (pulse_length_reg != TIME_RST);
            end else if (pls_cnt_reg >= pulse_length_reg) begin
                safe_reg.pulse_o <= 1'b0;
            end
            if (!dep_res_reg) begin
                safe_reg.start_o <= 1'b0;
            end else if (ctl_edge) begin
                safe_reg.start_o <= 1'b1;
            end
        end
    end

    // Lookup table on the selector value; signalling output frozen on error
    assign tbl_cnt = ctrl_reg[C_TBL_LSB +: 4];
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            table_reg <= 4'h0;
        end else if (!sync_clr) begin
            if (sel_value_reg == 4'h0 || sel_value_reg > tbl_cnt) begin
                table_reg <= 4'h0;
            end else begin
                table_reg <= conversion_table[3'(sel_value_reg - 4'h1)];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops
    assign axi_rsp = '{awready: awready_reg, wready: wready_reg, bvalid: bvalid_reg,
        bresp: bresp_reg, arready: arready_reg, rvalid: rvalid_reg, rdata: rdata_reg,
        rresp: rresp_reg};
    assign safe_out = safe_reg;
    assign table_result = table_reg;
    assign selector_value = sel_value_reg;
    assign monitor_error = {sel_err_reg, ind_err_reg, dep_err_reg, single_err_reg};
    assign error_state = mode_reg == SFB_ERROR;
endmodule : sfb_top
`default_nettype wire

// ==== inc/sfb_pkg.sv ====
// Package of constants, types and register map for the safety function blocks
// Function
// - Single contact: result while closed, no error
// - Single contact: error on electrical malfunction
// - Static signal: result while input active
// - Dependent pair: result when both normal, no error
// - Dependent pair: error on simultaneity or malfunction
// - Pair config: two NC or NO plus NC
// - Dependent pair takes simultaneity limit parameter
// - Independent pair: result when both normal, malfunction only
// - Selector outputs active position 1-8, 0 on error
// - Selector error: several, none, or malfunction
// - Selector position count from 2 to 8
// - AND asserts when all connected inputs asserted
// - NOR asserts when no connected input asserted
// - OR asserts when any connected input asserted
// - On-delay asserts after input held delay length
// - Off-delay holds output delay length after drop
// - Delay takes mode and delay length
// - Pulse asserts on falling edge for pulse length
// - Start latches on edge if enabled, holds while enabled
// - Start trigger selects rising or falling edge
// - Lookup table maps value, output starts at zero
// - Lookup table takes its entry count
// - Error state opens outputs, stops input evaluation
`default_nettype none
package sfb_pkg;
    // Timebase: one tick per millisecond
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned TICK_PERIOD_NS = 1000000;
    localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TW = 16;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] MASK_OFF = 8'h04;
    localparam logic [7:0] SIM_OFF = 8'h08;
    localparam logic [7:0] DLY_OFF = 8'h0C;
    localparam logic [7:0] PLS_OFF = 8'h10;
    localparam logic [7:0] STAT_OFF = 8'h14;
    localparam logic [2:0] TBL_PAGE = 3'h1;
    localparam int TBL_IDX_LSB = 2;
    localparam int TBL_N = 8;
    // Control fields
    localparam int C_DEP_CFG = 0;
    localparam int C_IND_CFG = 1;
    localparam int C_DLY_OFF = 2;
    localparam int C_START_FALL = 3;
    localparam int C_ERR_LOCK = 4;
    localparam int C_FORCE_ERR = 5;
    localparam int C_POS_LSB = 8;
    localparam int C_TBL_LSB = 12;
    localparam logic [31:0] CTRL_RST = 32'h0000_8800;
    // Mask fields, five monitor results each
    localparam int M_AND_LSB = 0;
    localparam int M_OR_LSB = 8;
    localparam int M_NOR_LSB = 16;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    localparam logic [TW-1:0] TIME_RST = 16'h0000;
    // Status fields
    localparam int S_SAFE_LSB = 0;
    localparam int S_MON_LSB = 8;
    localparam int S_ERR_LSB = 16;
    localparam int S_SEL_LSB = 24;
    localparam int S_STATE = 31;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] POS_MIN = 4'h2;
    localparam logic [3:0] POS_MAX = 4'h8;

    typedef struct packed {
        logic awvalid; logic [31:0] awaddr;
        logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
        logic bready;
        logic arvalid; logic [31:0] araddr;
        logic rready;
    } sfb_axi_req_t;
    typedef struct packed {
        logic awready; logic wready;
        logic bvalid; logic [1:0] bresp;
        logic arready;
        logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
    } sfb_axi_rsp_t;
    typedef struct packed {
        logic single; logic single_flt;
        logic stat;
        logic [1:0] dep; logic [1:0] dep_flt;
        logic [1:0] ind; logic [1:0] ind_flt;
        logic [7:0] sel; logic [7:0] sel_flt;
    } sfb_field_t;
    typedef struct packed {
        logic start_o; logic pulse_o; logic delay_o;
        logic nor_o; logic or_o; logic and_o;
    } sfb_safe_t;
    typedef enum logic {SFB_RUN, SFB_ERROR} sfb_mode_t;
    typedef enum logic [2:0] {R_CTRL, R_MASK, R_SIM, R_DLY, R_PLS,
        R_STAT, R_TBL, R_NONE} sfb_reg_t;
endpackage : sfb_pkg
`default_nettype wire

// ==== bench/sfb_field_model.sv ====
// Field contact model with a skewed second contact on the dependent pair
`default_nettype none
module sfb_field_model (
    input wire logic clk,
    input wire sfb_pkg::sfb_field_t want,
    input wire logic [7:0] lag,
    output var sfb_pkg::sfb_field_t pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt = 8'h00;
    // Slow contact trails by lag cycles, so simultaneity faults are real
    always @(posedge clk) begin
        cnt <= (want.dep[1] == pins.dep[1]) ? 8'h00 : cnt + 8'h01;
        pins <= want;
        if (want.dep[1] != pins.dep[1] && cnt < lag) begin
            pins.dep[1] <= pins.dep[1];
        end
    end
endmodule : sfb_field_model
`default_nettype wire

// ==== bench/sfb_chk.sv ====
// Port checker for the safety function blocks
`default_nettype none
module sfb_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire sfb_pkg::sfb_field_t field_pins,
    input wire sfb_pkg::sfb_safe_t safe_out,
    input wire logic [3:0] selector_value,
    input wire logic [3:0] monitor_error,
    input wire logic error_state
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    //////////////////////////////////////////////////////////////////////
    // Pins held six cycles clear the four-edge input pipeline
    err_open_a: assert property (error_state [*2] |-> safe_out == '0)
        else $error("safe output active in error state");
    err_hold_a: assert property (error_state |=> error_state)
        else $error("error state left without reset");
    sel_zero_a: assert property (monitor_error[3] [*2] |-> selector_value == 4'h0)
        else $error("selector value with error");
    sel_range_a: assert property (selector_value <= 4'h8)
        else $error("selector value out of range");
    single_err_a: assert property (field_pins.single_flt [*6] ##0 !error_state
        |-> monitor_error[0]) else $error("single contact fault missed");
    dep_err_a: assert property (field_pins.dep_flt[0] [*6] ##0 !error_state
        |-> monitor_error[1]) else $error("pair fault missed");
    ind_err_a: assert property (field_pins.ind_flt[1] [*6] ##0 !error_state
        |-> monitor_error[2]) else $error("independent fault missed");
    sel_none_a: assert property ((field_pins.sel == 8'h00) [*6] ##0 !error_state
        |-> monitor_error[3]) else $error("no position not flagged");
    cover property (safe_out.pulse_o);
    cover property (safe_out.start_o);
    cover property ($rose(error_state));
endmodule : sfb_chk
bind sfb_top sfb_chk chk_i (.clk(clk), .nrst(nrst), .field_pins(field_pins), .safe_out(safe_out),
    .selector_value(selector_value), .monitor_error(monitor_error), .error_state(error_state));
`default_nettype wire

// ==== bench/test_safety_function_blocks.sv ====
// Self-checking bench for the safety function blocks
`default_nettype none
module test_safety_function_blocks;
    timeunit 1ns;
    timeprecision 1ps;
    import sfb_pkg::*;
    typedef struct packed {sfb_field_t f; logic [2:0] lo; logic [3:0] sv;
        logic [3:0] tv;} sfb_row_t;
    // Rows: pins, {nor,or,and}, selector, table
    sfb_row_t rows [4] = '{'{27'h5000400, 3'h3, 4'h3, 4'hA}, '{27'h4008000, 3'h2, 4'h8, 4'h5},
        '{27'h0000600, 3'h4, 4'h0, 4'h0}, '{27'h6120000, 3'h4, 4'h0, 4'h0}};
    logic clk = 1'b0;
    logic nrst = 1'b0;
    sfb_axi_req_t rq = '0;
    sfb_axi_rsp_t rs;
    sfb_field_t want = '0;
    sfb_field_t pins;
    logic [7:0] lag = 8'h00;
    sfb_safe_t so;
    logic [3:0] tbl, sel, merr;
    logic est;
    logic [31:0] rd;
    int fails = 0;
    int cmp_count = 0;
    int c;
    sfb_top #(.TICK_CYCLES(4)) DUT (.clk(clk), .nrst(nrst), .axi_req(rq), .axi_rsp(rs),
        .field_pins(pins), .safe_out(so), .table_result(tbl), .selector_value(sel),
        .monitor_error(merr), .error_state(est));
    sfb_field_model fm (.clk(clk), .want(want), .lag(lag), .pins(pins));
    initial forever #2 clk = ~clk;
    // Hang guard, far beyond the planned sequence
    initial begin
        #200000;
        fails++;
        close_out();
    end
    //////////////////////////////////////////////////////////////////////
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : cmp
    // Each channel is released on its own handshake edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        rq.awvalid <= 1'b1;
        rq.wvalid <= 1'b1;
        rq.awaddr <= {24'h0, a};
        rq.wdata <= d;
        rq.wstrb <= 4'hF;
        rq.bready <= 1'b1;
        do begin
            @(posedge clk);
            if (rs.awready) rq.awvalid <= 1'b0;
            if (rs.wready) rq.wvalid <= 1'b0;
        end while (rs.bvalid !== 1'b1);
        cmp("bresp", 32'(RESP_OKAY), 32'(rs.bresp));
        rq.bready <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        rq.arvalid <= 1'b1;
        rq.araddr <= {24'h0, a};
        rq.rready <= 1'b1;
        do begin
            @(posedge clk);
            if (rs.arready) rq.arvalid <= 1'b0;
        end while (rs.rvalid !== 1'b1);
        rd = {rs.rresp[1:0] == RESP_SLVERR, rs.rdata[30:0]};
        rq.rready <= 1'b0;
    endtask : rdr
    // Counts cycles with safe output bit b high
    task automatic watch(input int n, input int b);
        c = 0;
        repeat (n) begin
            @(posedge clk);
            c += so[b];
        end
    endtask : watch
    task automatic close_out();
        if (fails == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    //////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        rdr(CTRL_OFF);
        cmp("ctrl", CTRL_RST, rd);
        rdr(8'h18);
        cmp("unmapped", 32'h80000000, rd);
        wr(8'h28, 32'hA);
        wr(8'h3C, 32'h5);
        wr(MASK_OFF, 32'h00030303);
        foreach (rows[i]) begin
            want <= rows[i].f;
            repeat (10) @(posedge clk);
            cmp("logic", 32'(rows[i].lo), 32'(so[2:0]));
            cmp("selector", 32'(rows[i].sv), 32'(sel));
            cmp("table", 32'(rows[i].tv), 32'(tbl));
        end
        wr(PLS_OFF, 32'h3);
        wr(DLY_OFF, 32'h3);
        wr(MASK_OFF, 32'h1);
        want <= '{single: 1'b1, default: '0};
        repeat (6) @(posedge clk);
        want.single <= 1'b0;
        watch(24, 4);
        cmp("pulse", 32'h1, 32'(c > 8 && c <= 13));
        want.single <= 1'b1;
        watch(12, 3);
        cmp("glitch", 32'h0, 32'(c));
        watch(8, 2);
        cmp("ondelay", 32'h1, 32'(so.delay_o));
        want.dep <= 2'b11;
        repeat (10) @(posedge clk);
        want.stat <= 1'b1;
        watch(10, 5);
        cmp("start", 32'h1, 32'(c > 0));
        want.dep <= 2'b00;
        watch(10, 5);
        cmp("release", 32'h1, 32'(so.start_o === 1'b0));
        wr(SIM_OFF, 32'h1);
        lag <= 8'd20;
        want.dep <= 2'b11;
        repeat (30) @(posedge clk);
        cmp("skew", 32'h1, 32'(merr[1]));
        wr(CTRL_OFF, CTRL_RST | 32'h20);
        repeat (8) @(posedge clk);
        cmp("error", 32'h1, {so, est});
        close_out();
    end
endmodule : test_safety_function_blocks
`default_nettype wire
